// file: pkg/sedfe_defs.vh
// constants for the serial eeprom bus front end
`ifndef SEDFE_DEFS_VH
`define SEDFE_DEFS_VH
// system clock rate
`define SEDFE_CLOCK_FREQ_KHZ 200000
// noise suppression width, 0.05 us
`define SEDFE_GLITCH_FILTER_WIDTH_NS 50
`define SEDFE_GLITCH_CYCLES ((`SEDFE_GLITCH_FILTER_WIDTH_NS * `SEDFE_CLOCK_FREQ_KHZ) / 1000000)
// longest self-timed program cycle
`define SEDFE_PROGRAM_CYCLE_TIME_MS 5
`define SEDFE_PROG_CYCLES (`SEDFE_PROGRAM_CYCLE_TIME_MS * `SEDFE_CLOCK_FREQ_KHZ)
// array geometry
`define SEDFE_ARRAY_DEPTH 16384
`define SEDFE_PAGE_SIZE 64
`define SEDFE_SERIAL_BYTES 16
// device type codes in bits 7:4 of the address byte
`define SEDFE_TYPE_MAIN 4'hA
`define SEDFE_TYPE_ID 4'hB
// access areas
`define SEDFE_AREA_MAIN 2'h0
`define SEDFE_AREA_IDPAGE 2'h1
`define SEDFE_AREA_LOCK 2'h2
`define SEDFE_AREA_SERIAL 2'h3
// field positions in the high address byte of the id type
`define SEDFE_AH_LOCK_BIT 2
`define SEDFE_AH_SERIAL_BIT 3
// lock request bit in the lock data byte
`define SEDFE_LOCK_DATA_BIT 1
`endif

// file: hdl/sedfe_glitch_filter.v
// two-flop synchroniser followed by a stable-level glitch filter
`timescale 1ns/10ps
`include "sedfe_defs.vh"
module sedfe_glitch_filter (
  input wire clock,
  input wire srst,
  input wire pinIn,
  output reg levelOut
);
  reg sync1_q; // first synchroniser stage, read only by sync2_q
  reg sync2_q; // second synchroniser stage
  reg [4:0] stableCnt_q; // cycles the new level has been held

  // synchronise, then accept a new level only once it held long enough
  always @(posedge clock) begin
    if (srst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      stableCnt_q <= 5'h00;
      levelOut <= 1'b0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      if (sync2_q == levelOut) begin
        stableCnt_q <= 5'h00; // no change pending
      end else if ({27'h0000000, stableCnt_q} == `SEDFE_GLITCH_CYCLES - 1) begin
        levelOut <= sync2_q; // held a full filter width, see [RL13]
        stableCnt_q <= 5'h00;
      end else begin
        stableCnt_q <= stableCnt_q + 5'h01; // shorter pulses are dropped
      end
    end
  end
endmodule

// file: hdl/sedfe_top.v
// bus-facing front end of a two-wire serial eeprom target
`timescale 1ns/10ps
`include "sedfe_defs.vh"
// Overview of operation
// [RL1] sample on clock rise, change on fall
// [RL2] data line only pulled low or released
// [RL3] floating chip-select inputs read as zero
// [RL4] three straps form device address bits
// [RL5] write-inhibit high refuses all writes
// [RL6] write-inhibit low or floating permits writes
// [RL7] stop after write starts timed program
// [RL8] transmitter changes data only while clock low
// [RL9] data change during clock high is start/stop
// [RL10] 16384 byte array in 64-byte pages
// [RL11] partial page writes program only sent bytes
// [RL12] lockable id page and read-only serial number
// [RL13] inputs filter pulses below suppression width
// [RL14] falling data with clock high is start
// [RL15] rising data with clock high is stop
// [RL16] acknowledge by pulling ninth clock low
// [RL17] match straps to acknowledge, else standby
// [RL18] inhibited write sequence never starts programming
module sedfe_top #(
  parameter PROG_CYCLES = `SEDFE_PROG_CYCLES,
  parameter [127:0] SERIAL_NUMBER = 128'h0123456789ABCDEF0123456789ABCDEF // arbitrary value
) (
  input wire clock,
  input wire srst,
  input wire sclPin,
  input wire sdaPinIn,
  output wire sdaPinOut,
  output wire sdaPinOe,
  input wire chipSelectBit0,
  input wire chipSelectBit1,
  input wire chipSelectBit2,
  input wire writeInhibitPin,
  output wire programBusy,
  output wire idPageLocked
);
  localparam [2:0] ST_IDLE = 3'h0; // standby, waits for a start
  localparam [2:0] ST_DEV = 3'h1; // receiving the device address byte
  localparam [2:0] ST_AH = 3'h2; // receiving the high word address
  localparam [2:0] ST_AL = 3'h3; // receiving the low word address
  localparam [2:0] ST_WR = 3'h4; // receiving write data
  localparam [2:0] ST_RD = 3'h5; // sending read data

  wire [5:0] rawPins; // pins from outside the clock domain
  wire [5:0] cleanPins; // synchronised and filtered pins
  wire sclF; // filtered serial clock
  wire sdaF; // filtered serial data
  wire [2:0] chipSel; // strapped chip-select bits
  wire writeInhibit; // filtered write-inhibit level

  reg [7:0] mainArray [0:`SEDFE_ARRAY_DEPTH-1]; // main storage
  reg [7:0] idPage [0:`SEDFE_PAGE_SIZE-1]; // extra lockable page
  reg [7:0] pageBuf [0:`SEDFE_PAGE_SIZE-1]; // staged page data

  reg sclPrev_q; // clock level one cycle back
  reg sdaPrev_q; // data level one cycle back
  reg [2:0] state_q; // protocol state
  reg [3:0] bitCnt_q; // clock rises within the byte, 8 = ack clock, 9 = after it
  reg [7:0] shift_q; // incoming byte
  reg [7:0] tx_q; // outgoing byte
  reg pullLow_q; // data line pulled low
  reg ack_q; // acknowledge the byte just received
  reg idType_q; // address byte named the id type
  reg [1:0] area_q; // selected access area
  reg [13:0] addr_q; // word address pointer
  reg [7:0] pageRow_q; // page row of the staged data
  reg pageIsId_q; // staged data targets the id page
  reg [63:0] pageMask_q; // staged bytes actually received
  reg lockReq_q; // lock request received
  reg lockPend_q; // lock applied at end of program cycle
  reg locked_q; // id page locked
  reg busy_q; // program cycle running
  reg [19:0] progCnt_q; // program cycle timer
  reg [6:0] progIdx_q; // commit pointer through the page

  wire sclRise = sclF & ~sclPrev_q;
  wire sclFall = ~sclF & sclPrev_q;
  // a data edge while the clock stays high is a bus condition, see [RL9]
  wire busStart = sclF & sclPrev_q & sdaPrev_q & ~sdaF; // see [RL14]
  wire busStop = sclF & sclPrev_q & ~sdaPrev_q & sdaF; // see [RL15]
  wire [7:0] rxByte = {shift_q[6:0], sdaF}; // byte complete at the 8th rise
  // writes allowed only while the inhibit level is low, see [RL5] [RL6]
  wire writeOk = ~writeInhibit;

  // read source for the current area and address
  function [7:0] read_byte;
    input [1:0] area;
    input [13:0] addr;
    begin
      if (area == `SEDFE_AREA_IDPAGE) begin
        read_byte = idPage[addr[5:0]];
      end else if (area == `SEDFE_AREA_LOCK) begin
        read_byte = {7'h00, locked_q};
      end else if (area == `SEDFE_AREA_SERIAL) begin
        read_byte = SERIAL_NUMBER[{addr[3:0], 3'h0} +: 8]; // read-only, see [RL12]
      end else begin
        read_byte = mainArray[addr];
      end
    end
  endfunction

  assign rawPins = {writeInhibitPin, chipSelectBit2, chipSelectBit1, chipSelectBit0,
                    sdaPinIn, sclPin};
  // every pin passes a synchroniser and filter; a floating strap is pulled low at the pad
  // and resets to zero here, see [RL3]
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : gPin
      sedfe_glitch_filter sedfe_glitch_filter_i (
        .clock(clock),
        .srst(srst),
        .pinIn(rawPins[gi]),
        .levelOut(cleanPins[gi])
      );
    end
  endgenerate
  assign sclF = cleanPins[0];
  assign sdaF = cleanPins[1];
  assign chipSel = cleanPins[4:2]; // device address bits 3:1, see [RL4]
  assign writeInhibit = cleanPins[5];

  // open drain: output level is always low, only the enable moves, see [RL2]
  assign sdaPinOut = 1'b0;
  assign sdaPinOe = pullLow_q;
  assign programBusy = busy_q;
  assign idPageLocked = locked_q;

  // staged page data, written as each data byte arrives
  always @(posedge clock) begin
    if (sclRise && bitCnt_q == 4'h7 && state_q == ST_WR && writeOk &&
        area_q != `SEDFE_AREA_LOCK && area_q != `SEDFE_AREA_SERIAL &&
        !(area_q == `SEDFE_AREA_IDPAGE && locked_q)) begin
      pageBuf[addr_q[5:0]] <= rxByte;
    end
  end

  // commit the staged bytes during the program cycle, one per clock
  always @(posedge clock) begin
    if (busy_q && !progIdx_q[6] && pageMask_q[progIdx_q[5:0]]) begin
      if (pageIsId_q) begin
        idPage[progIdx_q[5:0]] <= pageBuf[progIdx_q[5:0]];
      end else begin
        mainArray[{pageRow_q, progIdx_q[5:0]}] <= pageBuf[progIdx_q[5:0]]; // see [RL10] [RL11]
      end
    end
  end

  // protocol engine and program timer
  always @(posedge clock) begin
    if (srst) begin
      sclPrev_q <= 1'b0;
      sdaPrev_q <= 1'b0;
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      pullLow_q <= 1'b0;
      ack_q <= 1'b0;
      idType_q <= 1'b0;
      area_q <= `SEDFE_AREA_MAIN;
      addr_q <= 14'h0000;
      pageRow_q <= 8'h00;
      pageIsId_q <= 1'b0;
      pageMask_q <= 64'h0000000000000000;
      lockReq_q <= 1'b0;
      lockPend_q <= 1'b0;
      locked_q <= 1'b0;
      busy_q <= 1'b0;
      progCnt_q <= 20'h00000;
      progIdx_q <= 7'h00;
    end else begin
      sclPrev_q <= sclF;
      sdaPrev_q <= sdaF;
      // self-timed program cycle, finishes within the longest time, see [RL7]
      if (busy_q) begin
        if (!progIdx_q[6]) begin
          progIdx_q <= progIdx_q + 7'h01;
        end
        if ({12'h000, progCnt_q} == PROG_CYCLES - 1) begin
          busy_q <= 1'b0; // back to standby
          progCnt_q <= 20'h00000;
          if (lockPend_q) begin
            locked_q <= 1'b1;
          end
          lockPend_q <= 1'b0;
        end else begin
          progCnt_q <= progCnt_q + 20'h00001;
        end
      end
      if (busStart) begin
        // every command opens with a start, see [RL14]
        state_q <= ST_DEV;
        bitCnt_q <= 4'h0;
        pullLow_q <= 1'b0;
        ack_q <= 1'b0;
      end else if (busStop) begin
        pullLow_q <= 1'b0;
        state_q <= ST_IDLE;
        // launch programming only for a permitted write, see [RL18] [RL5]
        if (state_q == ST_WR && writeOk && !busy_q &&
            (pageMask_q != 64'h0000000000000000 || lockReq_q)) begin
          busy_q <= 1'b1; // see [RL7]
          progCnt_q <= 20'h00000;
          progIdx_q <= 7'h00;
          lockPend_q <= lockReq_q;
        end
        lockReq_q <= 1'b0;
      end else if (sclRise && state_q != ST_IDLE) begin
        // capture on the rising clock edge, see [RL1]
        if (bitCnt_q < 4'h8) begin
          shift_q <= rxByte;
          bitCnt_q <= bitCnt_q + 4'h1;
        end else begin
          bitCnt_q <= 4'h9; // ack clock done
        end
        if (bitCnt_q == 4'h7) begin
          ack_q <= 1'b1;
          case (state_q)
            ST_DEV: begin
              // compare type and strapped bits; busy means no answer, see [RL17]
              if (rxByte[7:5] == 3'h5 && rxByte[3:1] == chipSel && !busy_q) begin
                idType_q <= rxByte[4];
                if (!rxByte[4]) begin
                  area_q <= `SEDFE_AREA_MAIN;
                end
                state_q <= rxByte[0] ? ST_RD : ST_AH;
              end else begin
                ack_q <= 1'b0;
                state_q <= ST_IDLE; // mismatch returns to standby
              end
            end
            ST_AH: begin
              addr_q[13:8] <= rxByte[5:0];
              if (!idType_q) begin
                area_q <= `SEDFE_AREA_MAIN;
              end else if (rxByte[`SEDFE_AH_LOCK_BIT]) begin
                area_q <= `SEDFE_AREA_LOCK;
              end else if (rxByte[`SEDFE_AH_SERIAL_BIT]) begin
                area_q <= `SEDFE_AREA_SERIAL;
              end else begin
                area_q <= `SEDFE_AREA_IDPAGE;
              end
              state_q <= ST_AL;
            end
            ST_AL: begin
              addr_q[7:0] <= rxByte;
              pageRow_q <= {addr_q[13:8], rxByte[7:6]};
              pageIsId_q <= (area_q == `SEDFE_AREA_IDPAGE);
              pageMask_q <= 64'h0000000000000000;
              state_q <= ST_WR;
            end
            ST_WR: begin
              // refused data is not acknowledged and not staged, see [RL5]
              if (!writeOk || area_q == `SEDFE_AREA_SERIAL ||
                  (area_q == `SEDFE_AREA_IDPAGE && locked_q)) begin
                ack_q <= 1'b0;
              end else if (area_q == `SEDFE_AREA_LOCK) begin
                lockReq_q <= rxByte[`SEDFE_LOCK_DATA_BIT];
              end else begin
                pageMask_q[addr_q[5:0]] <= 1'b1; // only sent bytes, see [RL11]
                addr_q[5:0] <= addr_q[5:0] + 6'h01; // roll within the page
              end
            end
            default: begin
              ack_q <= 1'b0; // read bytes are answered by the host
            end
          endcase
        end
        if (bitCnt_q == 4'h8 && state_q == ST_RD && !ack_q) begin // not the address ack
          addr_q <= addr_q + 14'h0001; // pointer moves past the byte sent
          if (sdaF) begin
            state_q <= ST_IDLE; // host declined, wait for stop
          end
        end
      end else if (sclFall && state_q != ST_IDLE) begin
        // change output only after the falling edge, see [RL1] [RL8]
        if (bitCnt_q == 4'h8) begin
          pullLow_q <= ack_q; // ninth clock low, read bytes keep it clear, see [RL16]
        end else if (bitCnt_q == 4'h9) begin
          bitCnt_q <= 4'h0;
          if (state_q == ST_RD) begin
            tx_q <= read_byte(area_q, addr_q);
            pullLow_q <= (read_byte(area_q, addr_q) < 8'h80); // pull for a zero msb
          end else begin
            pullLow_q <= 1'b0;
          end
        end else if (state_q == ST_RD && bitCnt_q != 4'h0) begin
          pullLow_q <= ~tx_q[3'h7 - bitCnt_q[2:0]];
        end
      end else if (sclFall && state_q == ST_IDLE) begin
        pullLow_q <= 1'b0; // nothing to drive in standby
      end
    end
  end
endmodule

// file: bench/sedfe_host.sv
// two-wire host controller model that drives the serial clock and data line
`timescale 1ns/10ps
module sedfe_host (
  input wire clock,
  input wire sdaWire,
  output reg sclOut,
  output reg sdaOe
);
  // bus idle: clock high, data released to the pull-up
  initial begin
    sclOut = 1'h1;
    sdaOe = 1'h0;
  end
  // wait a number of system clock edges
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // one bit: data changes mid-low, holds through high, sampled mid-high
  task bitXfer(input logic b, output logic s);
    begin
      sclOut <= 1'h0;
      tick(8);
      sdaOe <= !b;
      tick(8);
      sclOut <= 1'h1;
      tick(8);
      s = sdaWire;
      tick(8);
    end
  endtask
  // start: data falls while clock high, also usable as a repeated start
  task start;
    begin
      sclOut <= 1'h0;
      tick(8);
      sdaOe <= 1'h0;
      tick(8);
      sclOut <= 1'h1;
      tick(8);
      sdaOe <= 1'h1;
      tick(8);
    end
  endtask
  // stop: data rises while clock high, then the bus idles
  task stop;
    begin
      sclOut <= 1'h0;
      tick(8);
      sdaOe <= 1'h1;
      tick(8);
      sclOut <= 1'h1;
      tick(8);
      sdaOe <= 1'h0;
      tick(24);
    end
  endtask
  // send a byte msb first and return the ninth bit (0 means acknowledge)
  task sendByte(input [7:0] d, output logic a);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitXfer(d[i], a);
      end
      bitXfer(1'h1, a);
    end
  endtask
  // read a byte msb first, then acknowledge or not
  task readByte(input logic ackIt, output [7:0] d);
    integer i;
    logic s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitXfer(1'h1, s);
        d[i] = s;
      end
      bitXfer(!ackIt, s);
    end
  endtask
endmodule

// file: bench/sedfe_top_monitor.sv
// assertion checker for the serial eeprom bus front end
`timescale 1ns/10ps
module sedfe_top_checker #(
  parameter PROG_CYCLES = 1000000
) (
  input wire clock,
  input wire srst,
  input wire sclPin,
  input wire sdaPinIn,
  input wire sdaPinOut,
  input wire sdaPinOe,
  input wire writeInhibitPin,
  input wire programBusy
);
  // busy cycles seen so far in the current program cycle
  reg [31:0] busyCnt_q;
  always @(posedge clock) begin
    busyCnt_q <= (srst || !programBusy) ? 32'h0 : busyCnt_q + 32'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  AST_OUT_LOW: assert property (sdaPinOut == 1'h0)
    else $error("data pin driven high");
  AST_RST: assert property (disable iff (1'h0) srst |=> !sdaPinOe && !programBusy)
    else $error("outputs not cleared by reset");
  AST_OE_SCL_LOW: assert property ($changed(sdaPinOe) |-> !sclPin)
    else $error("data changed while clock high");
  AST_OE_AFTER_FALL: assert property ($rose(sdaPinOe) |-> !sclPin && $past(sclPin, 17))
    else $error("data pull not launched by clock fall");
  AST_BUSY_LEN: assert property ($fell(programBusy) |-> busyCnt_q == PROG_CYCLES)
    else $error("program cycle length wrong");
  AST_BUSY_NO_OE: assert property (programBusy |-> !sdaPinOe)
    else $error("answer given while programming");
  AST_INHIBIT: assert property ($rose(programBusy) |-> !$past(writeInhibitPin, 16))
    else $error("program started while inhibited");
  AST_BUSY_AFTER_STOP: assert property ($rose(programBusy) |->
    sclPin && sdaPinIn && !$past(sdaPinIn, 20))
    else $error("program started without a stop");
endmodule
bind sedfe_top sedfe_top_checker #(.PROG_CYCLES(PROG_CYCLES)) sedfe_top_checker_i (
  .clock(clock),
  .srst(srst),
  .sclPin(sclPin),
  .sdaPinIn(sdaPinIn),
  .sdaPinOut(sdaPinOut),
  .sdaPinOe(sdaPinOe),
  .writeInhibitPin(writeInhibitPin),
  .programBusy(programBusy)
);

// file: bench/sedfe_top_bench.sv
// self-checking bench for the serial eeprom bus front end
`timescale 1ns/10ps
module sedfe_top_bench;
  localparam PROG = 600;
  reg clock = 1'h0;
  reg srst = 1'h1;
  reg [2:0] straps = 3'h5; // strapped chip-select inputs
  reg inhibit = 1'h0;
  reg ackBit;
  reg [7:0] rdByte;
  wire scl, hostOe, sdaOut, sdaOe, busy, locked;
  // open-drain wire with pull-up: low while any party pulls
  wire sdaWire = !(hostOe | sdaOe);
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  always #2.5 clock = !clock;
  sedfe_top #(.PROG_CYCLES(PROG)) sedfe_top_i (
    .clock(clock), .srst(srst), .sclPin(scl), .sdaPinIn(sdaWire),
    .sdaPinOut(sdaOut), .sdaPinOe(sdaOe), .chipSelectBit0(straps[0]),
    .chipSelectBit1(straps[1]), .chipSelectBit2(straps[2]),
    .writeInhibitPin(inhibit), .programBusy(busy), .idPageLocked(locked)
  );
  sedfe_host sedfe_host_i (.clock(clock), .sdaWire(sdaWire), .sclOut(scl), .sdaOe(hostOe));
  // print the verdict and end the run
  task complete_run;
    begin
      if (n_fail == 0 && checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // compare and count
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // start, device byte and two address bytes, each expecting an answer
  task header(input [7:0] dev, input [15:0] addr);
    begin
      sedfe_host_i.start;
      sedfe_host_i.sendByte(dev, ackBit);
      chk(ackBit, 8'h0);
      sedfe_host_i.sendByte(addr[15:8], ackBit);
      chk(ackBit, 8'h0);
      sedfe_host_i.sendByte(addr[7:0], ackBit);
      chk(ackBit, 8'h0);
    end
  endtask
  // random read of one byte ended by a not-acknowledge; dev is the write form
  task readAt(input [7:0] dev, input [15:0] addr, input [7:0] exp);
    begin
      header(dev, addr);
      sedfe_host_i.start;
      sedfe_host_i.sendByte(dev | 8'h01, ackBit);
      chk(ackBit, 8'h0);
      sedfe_host_i.readByte(1'h0, rdByte);
      chk(rdByte, exp);
      sedfe_host_i.stop;
    end
  endtask
  // device byte with other straps is ignored
  task testMismatch;
    begin
      sedfe_host_i.start;
      sedfe_host_i.sendByte(8'hA4, ackBit);
      chk(ackBit, 8'h1);
      sedfe_host_i.stop;
    end
  endtask
  // two-byte partial page write, busy poll, then read back
  task testWrite;
    begin
      header(8'hAA, 16'h0140);
      sedfe_host_i.sendByte(8'h5A, ackBit);
      chk(ackBit, 8'h0);
      sedfe_host_i.sendByte(8'hC3, ackBit);
      chk(ackBit, 8'h0);
      sedfe_host_i.stop;
      chk(busy, 8'h1);
      sedfe_host_i.start;
      sedfe_host_i.sendByte(8'hAA, ackBit);
      chk(ackBit, 8'h1);
      sedfe_host_i.stop;
      sedfe_host_i.tick(PROG);
      chk(busy, 8'h0);
      readAt(8'hAA, 16'h0140, 8'h5A);
      readAt(8'hAA, 16'h0141, 8'hC3);
    end
  endtask
  // inhibited write: data refused, no program cycle, contents kept
  task testInhibit;
    begin
      inhibit <= 1'h1;
      sedfe_host_i.tick(40);
      header(8'hAA, 16'h0140);
      sedfe_host_i.sendByte(8'h00, ackBit);
      chk(ackBit, 8'h1);
      sedfe_host_i.stop;
      sedfe_host_i.tick(40);
      chk(busy, 8'h0);
      inhibit <= 1'h0;
      sedfe_host_i.tick(40);
      readAt(8'hAA, 16'h0140, 8'h5A);
    end
  endtask
  // id page write and read back, lock it, then a refused id page write
  task testLock;
    begin
      header(8'hBA, 16'h0005);
      sedfe_host_i.sendByte(8'h96, ackBit);
      chk(ackBit, 8'h0);
      sedfe_host_i.stop;
      sedfe_host_i.tick(PROG + 40);
      readAt(8'hBA, 16'h0005, 8'h96);
      chk({7'h00, locked}, 8'h0);
      header(8'hBA, 16'h0400);
      sedfe_host_i.sendByte(8'h02, ackBit);
      chk(ackBit, 8'h0);
      sedfe_host_i.stop;
      sedfe_host_i.tick(PROG + 40);
      chk({7'h00, locked}, 8'h1);
      readAt(8'hBA, 16'h0400, 8'h01);
      header(8'hBA, 16'h0005);
      sedfe_host_i.sendByte(8'h3C, ackBit);
      chk(ackBit, 8'h1);
      sedfe_host_i.stop;
      sedfe_host_i.tick(40);
      chk(busy, 8'h0);
      readAt(8'hBA, 16'h0005, 8'h96);
    end
  endtask
  // cycle ceiling against a hang
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'h0;
    sedfe_host_i.tick(40);
    chk({5'h00, sdaOe, busy, locked}, 8'h0);
    testMismatch;
    testWrite;
    testInhibit;
    testLock;
    complete_run;
  end
endmodule
